// file: design/vic_regs.vh
// register map, field positions and vector addresses of the interrupt controller
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

`define VIC_OFF_REQ        8'h00
`define VIC_OFF_MASK       8'h04
`define VIC_OFF_LEVEL      8'h08
`define VIC_OFF_CTRL       8'h0C
`define VIC_OFF_STAT       8'h10
`define VIC_OFF_VTAB       8'h80

`define VIC_NSRC           18
`define VIC_NMASK          16
`define VIC_SRC_NMI        5'h10
`define VIC_SRC_SW         5'h11
`define VIC_SRC_LO_END     5'h09
`define VIC_SRC_HI         5'h0A

`define VIC_MASK_RST       16'hFFFF
`define VIC_LEVEL_RST      16'hFFFF
`define VIC_CTRL_RST       16'h0002

`define VIC_CTRL_IE        0
`define VIC_CTRL_ISP       1
`define VIC_CTRL_WDNMI     2
`define VIC_CTRL_CAPA      3
`define VIC_CTRL_CAPB      4
`define VIC_CTRL_WAKE      5
`define VIC_CTRL_ESEL      6
`define VIC_CTRL_CSEL      12

`define VIC_VEC_NMI        16'h0004
`define VIC_VEC_BASE       16'h0006
`define VIC_VEC_LO_END     16'h0016
`define VIC_VEC_HI         16'h0018
`define VIC_VEC_SW         16'h003E

`endif

// file: design/vic_ctrl.v
// vectored interrupt controller with ahb-lite register slave
// assumes single-word ahb transfers, one clock domain, raw pins asynchronous
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "vic_regs.vh"

module vic_ctrl (
   input  wire        clk,                        // 20 mhz system clock
   input  wire        rst_b,                      // async reset, active low
   input  wire        clk_en,                     // freezes all state when low
   input  wire        hsel,                       // ahb slave select
   input  wire [7:0]  haddr,                      // ahb byte address
   input  wire [1:0]  htrans,                     // ahb transfer type
   input  wire        hwrite,                     // ahb write
   input  wire [2:0]  hsize,                      // ahb size, word only
   input  wire [31:0] hwdata,                     // ahb write data
   input  wire        hready,                     // ahb bus ready
   output reg  [31:0] hrdata_r,                   // ahb read data
   output reg         hreadyout_r,                // ahb slave ready
   output reg         hresp_r,                    // ahb response, always okay
   input  wire        watchdog_overflow_irq,      // watchdog overflow pulse
   input  wire        pin_in_a,                   // external pin a, raw
   input  wire        pin_in_b,                   // external pin b, raw
   input  wire        pin_in_c,                   // external pin c, raw
   input  wire        mux_bus_rx_pin,             // mux bus receive line, raw
   input  wire        capture_input_a,            // timer16 capture pin a, raw
   input  wire        capture_input_b,            // timer16 capture pin b, raw
   input  wire        timer16_match_a,            // counter matches capcmp_reg_a
   input  wire        timer16_match_b,            // counter matches capcmp_reg_b
   input  wire        timer8_pwm_match_irq,       // 8-bit pwm timer match pulse
   input  wire        timer8_a_match_irq,         // 8-bit timer a match pulse
   input  wire        timer8_b_match_irq,         // 8-bit timer b match pulse
   input  wire        mux_bus_done_irq,           // mux bus transfer done pulse
   input  wire        mux_bus_rx_error_irq,       // mux bus rx error pulse
   input  wire        sync_serial_done_irq,       // sync serial done pulse
   input  wire        async_rx_done_irq,          // async receive done pulse
   input  wire        async_tx_done_irq,          // async transmit done pulse
   input  wire        adc_done_irq,               // conversion done pulse
   input  wire        software_trap_instruction,  // trap executed pulse
   input  wire        cpu_ack,                    // cpu accepts presented request
   input  wire        cpu_reti,                   // cpu returns from service
   output reg         irq_req_r,                  // request presented to cpu
   output reg  [4:0]  irq_src_r,                  // presented source number
   output reg  [15:0] irq_entry_r,                // service routine entry word
   output reg         irq_level_r                 // level interrupt line
);

   reg  [17:0] req_r;
   reg  [15:0] mask_r;
   reg  [15:0] level_r;
   reg  [15:0] ctrl_r;
   reg         save_ie_r;
   reg         save_isp_r;
   reg  [15:0] vec_mem [0:31];
   reg  [5:0]  sync1_r;
   reg  [5:0]  sync2_r;
   reg  [5:0]  sync3_r;
   reg         wr_pend_r;
   reg  [7:0]  wr_addr_r;
   reg  [17:0] ev;
   reg  [17:0] req_nxt;
   reg  [15:0] elig;
   reg  [4:0]  win;
   reg         win_any;
   reg  [31:0] rd_data;
   integer     i;

   wire [5:0]  rise = sync2_r & ~sync3_r;
   wire [5:0]  fall = ~sync2_r & sync3_r;
   wire        ie   = ctrl_r[`VIC_CTRL_IE];
   wire        in_service_level_flag  = ctrl_r[`VIC_CTRL_ISP];
   wire        acc  = cpu_ack & irq_req_r;
   wire        addr_ok = hsel & htrans[1] & hready;
   wire [31:0] w1c  = (wr_pend_r && wr_addr_r == `VIC_OFF_REQ) ? hwdata : 32'h0000_0000;

   // edge select: 01 rising, 10 falling, 11 both, 00 off
   function edge_hit;
      input [1:0] sel;
      input       r;
      input       f;
      begin
         edge_hit = (sel[0] & r) | (sel[1] & f);
      end
   endfunction

   // register write strobe for one offset, data phase only
   function wr_hit;
      input       pend;
      input [7:0] addr;
      input [7:0] off;
      begin
         wr_hit = pend & (addr == off);
      end
   endfunction

   // table address of a source
   // priorities 0 to 9 fit nine low words, so 9 shares the last one
   function [15:0] vec_addr;
      input [4:0] src;
      begin
         if (src == `VIC_SRC_NMI)
            vec_addr = `VIC_VEC_NMI;
         else if (src == `VIC_SRC_SW)
            vec_addr = `VIC_VEC_SW;
         else if (src >= `VIC_SRC_HI)
            vec_addr = `VIC_VEC_HI + {10'h000, src - `VIC_SRC_HI, 1'b0};
         else if (src == `VIC_SRC_LO_END)
            vec_addr = `VIC_VEC_LO_END;
         else
            vec_addr = `VIC_VEC_BASE + {10'h000, src, 1'b0};
      end
   endfunction

   // table address of the winner; word k of the table sits at address 2k
   wire [15:0] win_vec = vec_addr(win);

   // pin synchronisers, third stage only for edge detection
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
         sync3_r <= 6'h00;
      end else if (clk_en) begin
         sync1_r <= {capture_input_b, capture_input_a, mux_bus_rx_pin, pin_in_c, pin_in_b, pin_in_a};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // source events
   always @* begin
      ev     = 18'h0_0000;
      ev[0]  = watchdog_overflow_irq & ~ctrl_r[`VIC_CTRL_WDNMI];
      ev[16] = watchdog_overflow_irq & ctrl_r[`VIC_CTRL_WDNMI];
      ev[1]  = edge_hit(ctrl_r[`VIC_CTRL_ESEL+1:`VIC_CTRL_ESEL], rise[0], fall[0]);
      ev[2]  = edge_hit(ctrl_r[`VIC_CTRL_ESEL+3:`VIC_CTRL_ESEL+2], rise[1], fall[1]);
      ev[3]  = edge_hit(ctrl_r[`VIC_CTRL_ESEL+5:`VIC_CTRL_ESEL+4], rise[2], fall[2]);
      ev[4]  = ctrl_r[`VIC_CTRL_WAKE] & (rise[3] | fall[3]);
      ev[5]  = ctrl_r[`VIC_CTRL_CAPA] ?
               edge_hit(ctrl_r[`VIC_CTRL_CSEL+3:`VIC_CTRL_CSEL+2], rise[5], fall[5]) :
               timer16_match_a;
      ev[6]  = ctrl_r[`VIC_CTRL_CAPB] ?
               edge_hit(ctrl_r[`VIC_CTRL_CSEL+1:`VIC_CTRL_CSEL], rise[4], fall[4]) :
               timer16_match_b;
      ev[7]  = timer8_pwm_match_irq;
      ev[8]  = timer8_a_match_irq;
      ev[9]  = timer8_b_match_irq;
      ev[10] = mux_bus_done_irq;
      ev[11] = mux_bus_rx_error_irq;
      ev[12] = sync_serial_done_irq;
      ev[13] = async_rx_done_irq;
      ev[14] = async_tx_done_irq;
      ev[15] = adc_done_irq;
      ev[17] = software_trap_instruction;
   end

   // request flags: new event wins over ack and software clear
   always @* begin
      req_nxt = req_r & ~w1c[17:0];
      if (acc)
         req_nxt[irq_src_r] = 1'b0;
      req_nxt = req_nxt | ev;
   end

   // resolver: nmi, then trap, then high group, then low group
   always @* begin
      elig    = req_r[15:0] & ~mask_r & {16{ie}} & (~level_r | {16{in_service_level_flag}});
      win     = 5'h00;
      win_any = 1'b0;
      for (i = `VIC_NMASK - 1; i >= 0; i = i - 1) begin
         if (elig[i] & level_r[i]) begin
            win     = i[4:0];
            win_any = 1'b1;
         end
      end
      for (i = `VIC_NMASK - 1; i >= 0; i = i - 1) begin
         if (elig[i] & ~level_r[i]) begin
            win     = i[4:0];
            win_any = 1'b1;
         end
      end
      if (req_r[17]) begin
         win     = `VIC_SRC_SW;
         win_any = 1'b1;
      end
      if (req_r[16]) begin
         win     = `VIC_SRC_NMI;
         win_any = 1'b1;
      end
   end

   // read mux
   always @* begin
      rd_data = 32'h0000_0000;
      if (haddr == `VIC_OFF_REQ)
         rd_data = {14'h0000, req_r};
      else if (haddr == `VIC_OFF_MASK)
         rd_data = {16'h0000, mask_r};
      else if (haddr == `VIC_OFF_LEVEL)
         rd_data = {16'h0000, level_r};
      else if (haddr == `VIC_OFF_CTRL)
         rd_data = {16'h0000, ctrl_r};
      else if (haddr == `VIC_OFF_STAT)
         rd_data = {irq_entry_r, 8'h00, 2'b00, irq_src_r, irq_req_r};
      else if (haddr[7])
         rd_data = {16'h0000, vec_mem[haddr[6:2]]};
   end

   // ahb slave, zero wait states
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 8'h00;
         hrdata_r    <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else if (clk_en) begin
         wr_pend_r <= addr_ok & hwrite;
         if (addr_ok)
            wr_addr_r <= haddr;
         if (addr_ok & ~hwrite)
            hrdata_r <= rd_data;
      end
   end

   // vector table words, written by software
   always @(posedge clk) begin
      if (clk_en && wr_pend_r && wr_addr_r[7])
         vec_mem[wr_addr_r[6:2]] <= hwdata[15:0];
   end

   // request flags, one per source
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         req_r <= 18'h0_0000;
      else if (clk_en)
         req_r <= req_nxt;
   end

   // mask and level-select flags, written by software
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_r  <= `VIC_MASK_RST;
         level_r <= `VIC_LEVEL_RST;
      end else if (clk_en) begin
         if (wr_hit(wr_pend_r, wr_addr_r, `VIC_OFF_MASK))
            mask_r <= hwdata[15:0];
         if (wr_hit(wr_pend_r, wr_addr_r, `VIC_OFF_LEVEL))
            level_r <= hwdata[15:0];
      end
   end

   // control flags; accept saves and clears enable, return restores
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r     <= `VIC_CTRL_RST;
         save_ie_r  <= 1'b0;
         save_isp_r <= 1'b1;
      end else if (clk_en) begin
         if (wr_hit(wr_pend_r, wr_addr_r, `VIC_OFF_CTRL))
            ctrl_r <= hwdata[15:0];
         if (cpu_reti) begin
            ctrl_r[`VIC_CTRL_IE]  <= save_ie_r;
            ctrl_r[`VIC_CTRL_ISP] <= save_isp_r;
         end
         if (acc) begin
            save_ie_r            <= ie;
            save_isp_r           <= in_service_level_flag;
            ctrl_r[`VIC_CTRL_IE] <= 1'b0;
            if (irq_src_r[4] == 1'b0)
               ctrl_r[`VIC_CTRL_ISP] <= level_r[irq_src_r[3:0]];
         end
      end
   end

   // cpu handshake outputs
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req_r   <= 1'b0;
         irq_src_r   <= 5'h00;
         irq_entry_r <= 16'h0000;
         irq_level_r <= 1'b0;
      end else if (clk_en) begin
         // gap of one cycle after ack so the cleared flag is not re-offered
         // a flag that software clears this cycle is not offered either
         irq_req_r   <= win_any & ~acc & ~w1c[win];
         irq_src_r   <= win;
         irq_entry_r <= vec_mem[win_vec[5:1]];
         irq_level_r <= |(req_nxt[15:0] & ~mask_r) | req_nxt[16] | req_nxt[17];
      end
   end

endmodule // vic_ctrl

// file: sim/vic_cpu_model.sv
// cpu core model that accepts presented interrupt requests
// assumes the controller's registered request, source and entry outputs
`timescale 1ns/100ps
module vic_cpu_model (
   input  wire        clk,         // clock
   input  wire        rst_b,       // reset, low
   input  wire        en,          // accepting on
   input  wire [3:0]  dly,         // ack delay
   input  wire        irq_req_r,   // request in
   input  wire [4:0]  irq_src_r,   // source in
   input  wire [15:0] irq_entry_r, // entry in
   output reg         cpu_ack,     // accept strobe
   output reg  [4:0]  acc_src,     // last source
   output reg  [15:0] acc_entry,   // last entry
   output reg  [7:0]  acc_cnt      // accept count
);
   reg [3:0] wait_r;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_ack <= 1'b0;
         wait_r <= 4'h0;
         acc_cnt <= 8'h00;
         acc_src <= 5'h00;
         acc_entry <= 16'h0000;
      end else if (cpu_ack && irq_req_r) begin
         cpu_ack <= 1'b0;
         acc_src <= irq_src_r;
         acc_entry <= irq_entry_r;
         acc_cnt <= acc_cnt + 8'h01;
         wait_r <= 4'h0;
      end else if (en && irq_req_r && wait_r >= dly) begin
         cpu_ack <= 1'b1;
      end else begin
         // a withdrawn request also withdraws the ack
         cpu_ack <= 1'b0;
         wait_r <= irq_req_r ? wait_r + 4'h1 : 4'h0;
      end
   end
endmodule // vic_cpu_model

// file: sim/vic_ctrl_checker.sv
// port assertions for the interrupt controller
// assumes binding onto vic_ctrl, one clock domain
`timescale 1ns/100ps
module vic_ctrl_checker (
   input wire        clk,         // clock
   input wire        rst_b,       // reset, low
   input wire        clk_en,      // run enable
   input wire        cpu_ack,     // cpu accept
   input wire        hreadyout_r, // slave ready
   input wire        hresp_r,     // response
   input wire        irq_req_r,   // request out
   input wire [4:0]  irq_src_r,   // source out
   input wire [15:0] irq_entry_r, // entry out
   input wire        irq_level_r  // level line
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   property p_rdy; hreadyout_r; endproperty
   a_rdy: assert property (p_rdy) else $error("slave stalled");
   property p_okay; !hresp_r; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_ack; cpu_ack && irq_req_r && clk_en |=> !irq_req_r; endproperty
   a_ack: assert property (p_ack) else $error("request kept after accept");
   property p_lvl; irq_req_r |-> irq_level_r; endproperty
   a_lvl: assert property (p_lvl) else $error("request without level");
   property p_src; irq_req_r |-> irq_src_r <= 5'h11; endproperty
   a_src: assert property (p_src) else $error("source out of range");
   property p_frz; !clk_en |=> $stable(irq_req_r) && $stable(irq_src_r); endproperty
   a_frz: assert property (p_frz) else $error("request moved while frozen");
   property p_frz2; !clk_en |=> $stable(irq_entry_r) && $stable(irq_level_r); endproperty
   a_frz2: assert property (p_frz2) else $error("entry moved while frozen");
   property p_entry;
      irq_req_r && $past(irq_req_r) && $stable(irq_src_r) && $past(clk_en) |-> $stable(irq_entry_r);
   endproperty
   a_entry: assert property (p_entry) else $error("entry changed for same source");
endmodule // vic_ctrl_checker

bind vic_ctrl vic_ctrl_checker u_chk (.clk, .rst_b, .clk_en, .cpu_ack, .hreadyout_r, .hresp_r, .irq_req_r,
   .irq_src_r, .irq_entry_r, .irq_level_r);

// file: sim/vectored_interrupt_controller_tb_top.sv
// self-checking bench for the interrupt controller
// assumes vic_ctrl, the cpu model and the bound checker
`timescale 1ns/100ps
`include "vic_regs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module vectored_interrupt_controller_tb_top;
   logic        clk = 0, rst_b = 0, clk_en = 1, hsel = 0, hwrite = 0, en = 0, reti = 0;
   logic [7:0]  haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, q;
   logic [17:0] ev = 0;
   logic [5:0]  pins = 0;
   logic [3:0]  dly = 0;
   wire  [31:0] hrdata_r;
   wire         hreadyout_r, hresp_r, cpu_ack, irq_req_r, irq_level_r;
   wire  [4:0]  irq_src_r, acc_src;
   wire  [15:0] irq_entry_r, acc_entry;
   wire  [7:0]  acc_cnt;
   int          error_cnt = 0, check_count = 0, n;
   int          pri [4] = '{16, 7, 10, 15};
   // vector table address per source; 0 leaves the entry unchecked
   logic [15:0] vec [18] = '{16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014,
      16'h0016, 16'h0000, 16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0004, 16'h003E};
   logic [39:0] rv [5] = '{{`VIC_OFF_REQ, 32'h0}, {`VIC_OFF_MASK, 32'h0000_FFFF},
      {`VIC_OFF_LEVEL, 32'h0000_FFFF}, {`VIC_OFF_CTRL, 32'h0000_0002}, {8'h40, 32'h0}};
   always #25 clk = ~clk;
   vic_ctrl uut (.clk, .rst_b, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout_r), .hrdata_r, .hreadyout_r, .hresp_r, .watchdog_overflow_irq(ev[0] | ev[16]),
      .pin_in_a(pins[0]), .pin_in_b(pins[1]), .pin_in_c(pins[2]), .mux_bus_rx_pin(pins[3]),
      .capture_input_a(pins[4]), .capture_input_b(pins[5]), .timer16_match_a(ev[5]), .timer16_match_b(ev[6]),
      .timer8_pwm_match_irq(ev[7]), .timer8_a_match_irq(ev[8]), .timer8_b_match_irq(ev[9]),
      .mux_bus_done_irq(ev[10]), .mux_bus_rx_error_irq(ev[11]), .sync_serial_done_irq(ev[12]),
      .async_rx_done_irq(ev[13]), .async_tx_done_irq(ev[14]), .adc_done_irq(ev[15]),
      .software_trap_instruction(ev[17]), .cpu_ack, .cpu_reti(reti), .irq_req_r, .irq_src_r,
      .irq_entry_r, .irq_level_r);
   vic_cpu_model cpu (.clk, .rst_b, .en, .dly, .irq_req_r, .irq_src_r, .irq_entry_r, .cpu_ack, .acc_src,
      .acc_entry, .acc_cnt);
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rdy_wait;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout_r !== 1'b1 && n < 50);
      if (hreadyout_r !== 1'b1) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      rdy_wait();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      rdy_wait();
      q = hrdata_r;
   endtask
   task automatic fire(input int k);
      if (k >= 1 && k <= 4) pins[k - 1] <= ~pins[k - 1];
      else ev[k] <= 1'b1;
      @(posedge clk);
      ev <= '0;
   endtask
   task automatic accept(input logic [4:0] s, input logic [15:0] v);
      int c;
      c = acc_cnt;
      en <= 1'b1;
      for (n = 0; n < 100 && acc_cnt == c; n++) @(posedge clk);
      if (acc_cnt == c) begin
         error_cnt++;
         wrap_up();
      end
      `CHK("source", s, acc_src)
      if (v != 0) `CHK("entry", 16'hA000 + (v >> 1), acc_entry)
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 32; k++) bus(1'b1, 8'(8'h80 + 4 * k), 32'hA000 + k);
      bus(1'b1, `VIC_OFF_MASK, 32'h0);
      for (int k = 0; k < 18; k++) begin
         bus(1'b1, `VIC_OFF_CTRL, k == 16 ? 32'h0000_0FE7 : 32'h0000_0FE3);
         dly <= k[0] ? 4'h5 : 4'h0;
         fire(k);
         accept(5'(k), vec[k]);
         bus(1'b0, `VIC_OFF_REQ, 32'h0);
         `CHK("flag cleared", 32'h0, q)
      end
      // capture mode sources, then return restores enable
      bus(1'b1, `VIC_OFF_CTRL, 32'h0000_F01B);
      pins[5] <= 1'b1;
      accept(5'd5, vec[5]);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
      bus(1'b0, `VIC_OFF_CTRL, 32'h0);
      `CHK("enable restored", 32'h0000_F01B, q)
      pins[4] <= 1'b1;
      accept(5'd6, vec[6]);
      en <= 1'b0;
      // watchdog must be in non-maskable mode before the burst
      bus(1'b1, `VIC_OFF_CTRL, 32'h0000_0FE6);
      ev <= 18'h1_8480;
      @(posedge clk);
      ev <= '0;
      foreach (pri[i]) begin
         bus(1'b1, `VIC_OFF_CTRL, 32'h0000_0FE7);
         accept(5'(pri[i]), vec[pri[i]]);
      end
      bus(1'b1, `VIC_OFF_MASK, 32'h0000_FFFF);
      bus(1'b1, `VIC_OFF_CTRL, 32'h0000_0004);
      fire(16);
      fire(15);
      accept(5'h10, 16'h0004);
      bus(1'b0, `VIC_OFF_REQ, 32'h0);
      `CHK("masked pending", 32'h0000_8000, q)
      `CHK("line masked", 1'b0, irq_level_r)
      bus(1'b1, `VIC_OFF_MASK, 32'h0);
      bus(1'b1, `VIC_OFF_CTRL, 32'h0000_0001);
      bus(1'b0, `VIC_OFF_REQ, 32'h0);
      `CHK("line unmasked", 1'b1, irq_level_r)
      `CHK("low level blocked", 1'b0, irq_req_r)
      bus(1'b1, `VIC_OFF_LEVEL, 32'h0000_7FFF);
      accept(5'd15, vec[15]);
      fire(14);
      bus(1'b1, `VIC_OFF_REQ, 32'h0000_4000);
      bus(1'b0, `VIC_OFF_REQ, 32'h0);
      `CHK("status cleared", 32'h0, q)
      `CHK("line idle", 1'b0, irq_level_r)
      clk_en <= 1'b0;
      repeat (3) @(posedge clk);
      clk_en <= 1'b1;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("line in reset", 1'b0, irq_req_r)
      rst_b <= 1'b1;
      @(posedge clk);
      foreach (rv[i]) begin
         bus(1'b0, rv[i][39:32], 32'h0);
         `CHK("reset value", rv[i][31:0], q)
      end
      wrap_up();
   end
endmodule // vectored_interrupt_controller_tb_top
